// [sfrc_pkg.sv]
package sfrc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_LEN = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_DATA = 8'h14;
  localparam logic [7:0] OFF_CUR_ADDR = 8'h18;

  // Control register fields
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_QPI_BIT = 3;
  localparam int CTRL_WIDE_BIT = 4;
  localparam int CTRL_EAR_BIT = 5;
  localparam int CTRL_DC_LSB = 6;
  localparam int CTRL_QE_BIT = 8;
  localparam int CTRL_BUSY_BIT = 9;
  localparam int CTRL_WIDTH = 10;

  // Command and status fields
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_STOP_BIT = 3;

  // Reset values
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [15:0] LEN_RESET = 16'h0001;

  // Read types
  localparam logic [2:0] RT_FAST = 3'h0;
  localparam logic [2:0] RT_DUAL_OUT = 3'h1;
  localparam logic [2:0] RT_DUAL_IO = 3'h2;
  localparam logic [2:0] RT_QUAD_OUT = 3'h3;
  localparam logic [2:0] RT_QUAD_IO = 3'h4;

  // Opcodes
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;

  // Clock counts, default address width and mode byte
  localparam int HALF_PERIOD_DEFAULT = 4;
  localparam int HALF_PERIOD_MIN = 3;
  localparam int MEM_ADDR_BITS_DEFAULT = 25;
  localparam logic [5:0] CMD_CLOCKS_SINGLE = 6'h08;
  localparam logic [5:0] CMD_CLOCKS_QUAD = 6'h02;
  localparam logic [5:0] MODE_CLOCKS = 6'h02;
  localparam logic [7:0] MODE_BITS = 8'h00;

  function automatic logic [7:0] opcode_of(input logic [2:0] t);
    unique case (t)
      RT_DUAL_OUT: opcode_of = OP_DUAL_OUT;
      RT_DUAL_IO: opcode_of = OP_DUAL_IO;
      RT_QUAD_OUT: opcode_of = OP_QUAD_OUT;
      RT_QUAD_IO: opcode_of = OP_QUAD_IO;
      default: opcode_of = OP_FAST;
    endcase
  endfunction

  function automatic logic [2:0] addr_lanes(input logic [2:0] t);
    addr_lanes = (t == RT_DUAL_IO) ? 3'h2 : (t == RT_QUAD_IO) ? 3'h4 : 3'h1;
  endfunction

  function automatic logic [2:0] data_lanes(input logic [2:0] t);
    data_lanes = (t == RT_DUAL_OUT || t == RT_DUAL_IO) ? 3'h2 :
                 (t == RT_QUAD_OUT || t == RT_QUAD_IO) ? 3'h4 : 3'h1;
  endfunction

  function automatic logic [5:0] dummy_clocks(input logic [2:0] t, input logic [1:0] dc);
    logic [5:0] r;
    r = 6'h08;
    if (t == RT_DUAL_IO) begin
      unique case (dc)
        2'h0: r = 6'h04;
        2'h1: r = 6'h06;
        2'h2: r = 6'h08;
        default: r = 6'h0a;
      endcase
    end else if (t == RT_QUAD_IO) begin
      unique case (dc)
        2'h0: r = 6'h06;
        2'h1: r = 6'h04;
        2'h2: r = 6'h08;
        default: r = 6'h0a;
      endcase
    end else begin
      unique case (dc)
        2'h0: r = 6'h08;
        2'h1: r = 6'h06;
        2'h2: r = 6'h08;
        default: r = 6'h0a;
      endcase
    end
    dummy_clocks = r;
  endfunction

endpackage

// [sfrc_tick_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module sfrc_tick_gen #(
  parameter int HALF = sfrc_pkg::HALF_PERIOD_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic clear,
  // Serial clock edge requests
  output logic tick_rise,
  output logic tick_fall
);

  logic [7:0] cnt_q;
  logic phase_q;
  wire wrap_w = (cnt_q == 8'(HALF - 1));

  // Frozen while stalled so the serial clock simply stretches
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      phase_q <= 1'b0;
    end else if (clear) begin
      cnt_q <= 8'h00;
      phase_q <= 1'b0;
    end else if (run) begin
      if (wrap_w) begin
        cnt_q <= 8'h00;
        phase_q <= ~phase_q;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign tick_rise = run & ~clear & wrap_w & ~phase_q;
  assign tick_fall = run & ~clear & wrap_w & phase_q;

endmodule
`default_nettype wire

// [sfrc_host.sv]
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module sfrc_host #(
  parameter int HALF_PERIOD = sfrc_pkg::HALF_PERIOD_DEFAULT,
  parameter int MEM_ADDR_BITS = sfrc_pkg::MEM_ADDR_BITS_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash select and clock
  output logic flash_cs_n,
  output logic flash_sclk,
  // Flash data lines
  input wire logic io_line_0_in,
  output logic io_line_0_out,
  output logic io_line_0_oe,
  input wire logic io_line_1_in,
  output logic io_line_1_out,
  output logic io_line_1_oe,
  input wire logic io_line_2_in,
  output logic io_line_2_out,
  output logic io_line_2_oe,
  input wire logic io_line_3_in,
  output logic io_line_3_out,
  output logic io_line_3_oe
);

  if (HALF_PERIOD < sfrc_pkg::HALF_PERIOD_MIN || HALF_PERIOD > 255 ||
      MEM_ADDR_BITS < 1 || MEM_ADDR_BITS > 32) begin : g_bad_param
    $error("Parameter out of range");
  end

  localparam logic [31:0] ADDR_MASK = 32'((64'h1 << MEM_ADDR_BITS) - 64'h1);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_CMD = 6'h02,
    S_ADDR = 6'h04,
    S_DUMMY = 6'h08,
    S_DATA = 6'h10,
    S_END = 6'h20
  } sfrc_state_type;

  sfrc_state_type state_q;
  logic [9:0] ctrl_q;
  logic [31:0] addr_q, cur_addr_q, tx_q, prdata_q;
  logic [15:0] len_q, left_q;
  logic [7:0] rx_q, data_q;
  logic [5:0] cnt_q;
  logic [3:0] bitc_q, sync1_q, sync2_q, io_out_q, io_oe_q, lane_out_d, lane_oe_d;
  logic [2:0] type_q;
  logic [1:0] dc_q;
  logic qpi_q, wide_q, valid_q, refused_q, stop_q, sclk_q, cs_n_q;
  logic pready_q, pslverr_q, tick_rise, tick_fall;

  // Pin synchronisers and registered pin drive
  wire [3:0] io_in_w = {io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
    end else begin
      sync1_q <= io_in_w;
      sync2_q <= sync1_q;
      io_out_q <= lane_out_d;
      io_oe_q <= lane_oe_d;
    end
  end

  // State decode
  wire st_idle = (state_q == S_IDLE);
  wire st_cmd = (state_q == S_CMD);
  wire st_addr = (state_q == S_ADDR);
  wire st_dummy = (state_q == S_DUMMY);
  wire st_data = (state_q == S_DATA);
  wire st_end = (state_q == S_END);

  // APB decode
  wire access_w = psel & penable & ~pready_q;
  wire wr_fire = psel & penable & pready_q & pwrite;
  wire rd_fire = psel & penable & pready_q & ~pwrite;
  wire page_ok = (paddr[31:8] == 24'h000000);
  wire sel_ctrl = page_ok & (paddr[7:0] == sfrc_pkg::OFF_CTRL);
  wire sel_addr = page_ok & (paddr[7:0] == sfrc_pkg::OFF_ADDR);
  wire sel_len = page_ok & (paddr[7:0] == sfrc_pkg::OFF_LEN);
  wire sel_cmd = page_ok & (paddr[7:0] == sfrc_pkg::OFF_CMD);
  wire sel_status = page_ok & (paddr[7:0] == sfrc_pkg::OFF_STATUS);
  wire sel_data = page_ok & (paddr[7:0] == sfrc_pkg::OFF_DATA);
  wire sel_cur = page_ok & (paddr[7:0] == sfrc_pkg::OFF_CUR_ADDR);
  wire hit_w = sel_ctrl | sel_addr | sel_len | sel_cmd | sel_status | sel_data | sel_cur;

  wire [31:0] status_w = {left_q, 12'h000, stop_q, refused_q, valid_q, ~st_idle};
  wire [31:0] rd_word_w = sel_ctrl ? {22'h000000, ctrl_q} :
                          sel_addr ? addr_q :
                          sel_len ? {16'h0000, len_q} :
                          sel_status ? status_w :
                          sel_data ? {24'h000000, data_q} :
                          sel_cur ? cur_addr_q : 32'h0000_0000;

  // Control fields as written by software
  wire [2:0] c_type = ctrl_q[sfrc_pkg::CTRL_TYPE_LSB +: 3];
  wire c_qpi = ctrl_q[sfrc_pkg::CTRL_QPI_BIT];
  wire c_wide = ctrl_q[sfrc_pkg::CTRL_WIDE_BIT];
  wire c_ear = ctrl_q[sfrc_pkg::CTRL_EAR_BIT];
  wire c_qe = ctrl_q[sfrc_pkg::CTRL_QE_BIT];
  wire c_busy = ctrl_q[sfrc_pkg::CTRL_BUSY_BIT];

  // Start checks
  wire start_req = wr_fire & sel_cmd & pwdata[sfrc_pkg::CMD_START_BIT];
  wire stop_req = wr_fire & sel_cmd & pwdata[sfrc_pkg::CMD_STOP_BIT];
  wire bad_busy = c_busy;
  wire bad_qe = (c_type == sfrc_pkg::RT_QUAD_IO) & ~c_qe;
  wire bad_qpi = c_qpi & (c_type != sfrc_pkg::RT_QUAD_IO);
  wire bad_high = ~c_wide & ~c_ear & (addr_q[31:24] != 8'h00);
  wire bad_type = (c_type > sfrc_pkg::RT_QUAD_IO) | (len_q == 16'h0000);
  wire start_bad = ~st_idle | bad_busy | bad_qe | bad_qpi | bad_high | bad_type;
  wire start_ok = start_req & ~start_bad;
  wire refuse_set = start_req & start_bad;

  // Phase geometry from the latched read type
  wire [2:0] cw_w = qpi_q ? 3'h4 : 3'h1;
  wire [2:0] aw_w = sfrc_pkg::addr_lanes(type_q);
  wire [2:0] dw_w = sfrc_pkg::data_lanes(type_q);
  wire [2:0] lane_w = st_cmd ? cw_w : (st_addr | st_dummy) ? aw_w : dw_w;
  wire [5:0] addr_clocks_w = (aw_w == 3'h4) ? (wide_q ? 6'h08 : 6'h06) :
                             (aw_w == 3'h2) ? (wide_q ? 6'h10 : 6'h0c) :
                             (wide_q ? 6'h20 : 6'h18);
  wire [5:0] dummy_w = sfrc_pkg::dummy_clocks(type_q, dc_q);
  wire [3:0] cpb_w = (dw_w == 3'h4) ? 4'h2 : (dw_w == 3'h2) ? 4'h4 : 4'h8;
  wire mode_w = (type_q == sfrc_pkg::RT_QUAD_IO) & ((dummy_w - cnt_q) < sfrc_pkg::MODE_CLOCKS);

  // Top bits leave first, top line carries the top bit
  wire [31:0] tx_shift_w = (lane_w == 3'h4) ? {tx_q[27:0], 4'h0} :
                           (lane_w == 3'h2) ? {tx_q[29:0], 2'h0} : {tx_q[30:0], 1'b0};
  wire [3:0] drive_w = (lane_w == 3'h4) ? tx_q[31:28] :
                       (lane_w == 3'h2) ? {2'b11, tx_q[31:30]} : {3'b110, tx_q[31]};
  wire [7:0] rx_next_w = (dw_w == 3'h4) ? {rx_q[3:0], sync2_q} :
                         (dw_w == 3'h2) ? {rx_q[5:0], sync2_q[1:0]} : {rx_q[6:0], sync2_q[1]};
  wire [31:0] addr_load_w = wide_q ? cur_addr_q : {cur_addr_q[23:0], 8'h00};
  wire [31:0] addr_inc_w = (cur_addr_q + 32'h0000_0001) & ADDR_MASK;

  // Lane drive per phase; spare lanes held high as write protect and hold, except lines 2 and 3 released in the quad output dummy phase
  always_comb begin
    lane_out_d = 4'h0;
    lane_oe_d = 4'h0;
    unique case (state_q)
      S_IDLE, S_END: lane_out_d = 4'h0;
      S_CMD, S_ADDR: begin
        lane_out_d = drive_w;
        lane_oe_d = (lane_w == 3'h1) ? 4'hd : 4'hf;
      end
      S_DUMMY: begin
        if (type_q == sfrc_pkg::RT_QUAD_IO) begin
          lane_oe_d = mode_w ? 4'hf : 4'h0;
          lane_out_d = 4'h0;
        end else if (type_q == sfrc_pkg::RT_DUAL_IO) begin
          lane_oe_d = 4'hc;
          lane_out_d = 4'hc;
        end else if (type_q == sfrc_pkg::RT_QUAD_OUT) begin
          lane_oe_d = 4'h1;
          lane_out_d = 4'h0;
        end else begin
          lane_oe_d = 4'hd;
          lane_out_d = 4'hc;
        end
      end
      S_DATA: begin
        lane_oe_d = (dw_w == 3'h4) ? 4'h0 : (dw_w == 3'h2) ? 4'hc : 4'hd;
        lane_out_d = 4'hc;
      end
    endcase
  end

  // Stall before the next rise while a byte waits unread
  wire stall_w = st_data & valid_q & ~sclk_q & ~stop_q;
  wire run_w = ~st_idle & ~stall_w;

  sfrc_tick_gen #(.HALF(HALF_PERIOD)) u_tick (
    .clock(clock),
    .rst(rst),
    .run(run_w),
    .clear(st_idle),
    .tick_rise(tick_rise),
    .tick_fall(tick_fall)
  );

  // APB registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      ctrl_q <= sfrc_pkg::CTRL_RESET;
      addr_q <= sfrc_pkg::ADDR_RESET;
      len_q <= sfrc_pkg::LEN_RESET;
    end else begin
      pready_q <= access_w;
      pslverr_q <= access_w & ~hit_w;
      if (access_w) begin
        prdata_q <= (hit_w & ~pwrite) ? rd_word_w : 32'h0000_0000;
      end
      if (wr_fire & sel_ctrl) begin
        ctrl_q <= pwdata[9:0];
      end
      if (wr_fire & sel_addr) begin
        addr_q <= pwdata;
      end
      if (wr_fire & sel_len) begin
        len_q <= pwdata[15:0];
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  wire refused_clr = wr_fire & sel_status & pwdata[sfrc_pkg::STAT_REFUSED_BIT];
  wire valid_set = st_data & tick_rise & (bitc_q == 4'h1);
  wire valid_clr = rd_fire & sel_data;

  // Sequencer; lines change after falls, device samples on rises
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refused_q <= 1'b0;
      valid_q <= 1'b0;
      state_q <= S_IDLE;
      cnt_q <= 6'h00;
      bitc_q <= 4'h0;
      tx_q <= 32'h0000_0000;
      rx_q <= 8'h00;
      data_q <= 8'h00;
      left_q <= 16'h0000;
      cur_addr_q <= 32'h0000_0000;
      type_q <= sfrc_pkg::RT_FAST;
      dc_q <= 2'h0;
      qpi_q <= 1'b0;
      wide_q <= 1'b0;
      stop_q <= 1'b0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      refused_q <= refuse_set | (refused_q & ~refused_clr);
      valid_q <= valid_set | (valid_q & ~valid_clr);
      if (tick_rise & ~st_end) begin
        sclk_q <= 1'b1;
      end
      if (tick_fall) begin
        sclk_q <= 1'b0;
      end
      if (stop_req & ~st_idle) begin
        stop_q <= 1'b1;
      end
      unique case (state_q)
        S_IDLE: begin
          if (start_ok) begin
            type_q <= c_type;
            qpi_q <= c_qpi;
            wide_q <= c_wide;
            dc_q <= ctrl_q[sfrc_pkg::CTRL_DC_LSB +: 2];
            cs_n_q <= 1'b0;
            state_q <= S_CMD;
            cnt_q <= c_qpi ? sfrc_pkg::CMD_CLOCKS_QUAD : sfrc_pkg::CMD_CLOCKS_SINGLE;
            tx_q <= {sfrc_pkg::opcode_of(c_type), 24'h000000};
            left_q <= len_q;
            cur_addr_q <= addr_q & ADDR_MASK;
            stop_q <= 1'b0;
          end
        end
        S_CMD: begin
          if (tick_fall) begin
            if (cnt_q == 6'h01) begin
              state_q <= S_ADDR;
              cnt_q <= addr_clocks_w;
              tx_q <= addr_load_w;
            end else begin
              cnt_q <= cnt_q - 6'h01;
              tx_q <= tx_shift_w;
            end
          end
        end
        S_ADDR: begin
          if (tick_fall) begin
            if (cnt_q == 6'h01) begin
              state_q <= S_DUMMY;
              cnt_q <= dummy_w;
              tx_q <= {sfrc_pkg::MODE_BITS, 24'h000000};
            end else begin
              cnt_q <= cnt_q - 6'h01;
              tx_q <= tx_shift_w;
            end
          end
        end
        S_DUMMY: begin
          if (tick_fall) begin
            if (cnt_q == 6'h01) begin
              state_q <= S_DATA;
              bitc_q <= cpb_w;
            end else begin
              cnt_q <= cnt_q - 6'h01;
            end
          end
        end
        S_DATA: begin
          if (tick_rise) begin
            rx_q <= rx_next_w;
            if (bitc_q == 4'h1) begin
              data_q <= rx_next_w;
              left_q <= left_q - 16'h0001;
              cur_addr_q <= addr_inc_w;
              bitc_q <= cpb_w;
            end else begin
              bitc_q <= bitc_q - 4'h1;
            end
          end
          if (tick_fall & (stop_q | (left_q == 16'h0000))) begin
            state_q <= S_END;
            cs_n_q <= 1'b1;
          end
        end
        S_END: begin
          if (tick_rise) begin
            state_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flash_cs_n = cs_n_q;
  assign flash_sclk = sclk_q;
  assign {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} = io_out_q;
  assign {io_line_3_oe, io_line_2_oe, io_line_1_oe, io_line_0_oe} = io_oe_q;

endmodule
`default_nettype wire

// [sfrc_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none
module sfrc_flash_model #(
  parameter int ABITS = 25
) (
  // Select and clock
  input wire logic cs_n,
  input wire logic sclk,
  // Resolved pins and drive
  input wire logic [3:0] io,
  output logic [3:0] dev,
  // Read setup told by the bench
  input wire logic [2:0] rtype,
  input wire logic four_wire_command_mode,
  input wire logic wide,
  input wire logic [1:0] dc,
  // What the device received
  output logic [7:0] got_op,
  output logic [31:0] got_addr
);
  localparam logic [31:0] AMASK = (32'h1 << ABITS) - 32'h1;
  int n = 0;
  int k, al, dl, oc, ac, dm, hdr;
  logic [7:0] b;
  initial dev = 4'h0;
  always @* begin
    al = (rtype == 3'h2) ? 2 : (rtype == 3'h4) ? 4 : 1;
    dl = (rtype == 3'h1 || rtype == 3'h2) ? 2 : (rtype == 3'h0) ? 1 : 4;
    oc = four_wire_command_mode ? 2 : 8;
    ac = (wide ? 32 : 24) / al;
    dm = (dc == 2'h2) ? 8 : (dc == 2'h3) ? 10 : (rtype == 3'h2) ? (dc == 2'h0 ? 4 : 6) :
         (rtype == 3'h4) ? (dc == 2'h0 ? 6 : 4) : (dc == 2'h0 ? 8 : 6);
    hdr = oc + ac + dm;
  end
  always @(negedge cs_n) begin
    n = 0;
    got_op = 8'h0;
    got_addr = 32'h0;
  end
  // Header taken at the rise, top line first
  always @(posedge sclk) begin
    if (!cs_n) begin
      n = n + 1;
      if (n <= oc) begin
        got_op = four_wire_command_mode ? {got_op[3:0], io} : {got_op[6:0], io[0]};
      end else if (n <= oc + ac) begin
        got_addr = (al == 4) ? {got_addr[27:0], io} : (al == 2) ? {got_addr[29:0], io[1:0]} :
                   {got_addr[30:0], io[0]};
      end
    end
  end
  // Released lines flip so a stale level never looks valid
  always @(negedge sclk or posedge cs_n) begin
    if (!cs_n && n >= hdr) begin
      k = n - hdr;
      b = ((got_addr + 32'(k / (8 / dl))) & AMASK) ^ (got_addr + 32'(k / (8 / dl)) >> 8) ^ 8'h3c;
      b = ((((got_addr + 32'(k / (8 / dl))) & AMASK) >> 8) ^ b ^ b ^ ((got_addr + 32'(k / (8 / dl)))
        & AMASK)) ^ 8'h3c;
      b = b << ((k % (8 / dl)) * dl);
      dev = (dl == 4) ? b[7:4] : (dl == 2) ? {~dev[3:2], b[7:6]} :
            {~dev[3:2], b[7], ~dev[0]};
    end else begin
      dev = ~dev;
    end
  end
endmodule
`default_nettype wire

// [sfrc_host_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module sfrc_host_checker #(
  parameter int HALF_PERIOD = 4,
  parameter int MEM_ADDR_BITS = 25
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input wire logic flash_cs_n,
  input wire logic flash_sclk,
  input wire logic io_line_0_out,
  input wire logic io_line_0_oe,
  input wire logic io_line_1_oe,
  input wire logic io_line_2_oe,
  input wire logic io_line_3_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Checks assume the default half period of four
  sequence s_lead;
    !flash_sclk [*4] ##1 flash_sclk;
  endsequence
  sequence s_high;
    flash_sclk [*4] ##1 !flash_sclk;
  endsequence
  chk_cs_lead: assert property ($fell(flash_cs_n) |-> s_lead)
    else $error("first clock rise late");
  chk_high_phase: assert property ($rose(flash_sclk) |-> s_high)
    else $error("clock high phase wrong");
  chk_sclk_idle: assert property (flash_cs_n |-> !flash_sclk)
    else $error("clock runs while deselected");
  chk_oe_released: assert property (flash_cs_n && $past(flash_cs_n) |->
    !(io_line_0_oe || io_line_1_oe || io_line_2_oe || io_line_3_oe))
    else $error("lines driven while deselected");
  // First bit is set up before the first rise, so skip the select edge
  chk_out_after_fall: assert property (!flash_cs_n && !$past(flash_cs_n, 2) &&
    $changed(io_line_0_out) |-> $past(flash_sclk, 2) && !$past(flash_sclk))
    else $error("line changed away from fall");
  chk_cs_tail: assert property ($rose(flash_cs_n) |-> flash_cs_n [*4])
    else $error("select high too short");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not after one wait");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  chk_unmapped: assert property (psel && penable && pready && (paddr[31:8] != 24'h0 ||
    paddr[7:0] > sfrc_pkg::OFF_CUR_ADDR || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind sfrc_host sfrc_host_checker #(.HALF_PERIOD(HALF_PERIOD), .MEM_ADDR_BITS(MEM_ADDR_BITS))
  i_chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk), .io_line_0_out(io_line_0_out),
  .io_line_0_oe(io_line_0_oe), .io_line_1_oe(io_line_1_oe), .io_line_2_oe(io_line_2_oe),
  .io_line_3_oe(io_line_3_oe));
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top;
  localparam logic [31:0] AMASK = 32'h01ff_ffff;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, rerr, flash_cs_n, flash_sclk, mq, mw;
  logic [31:0] paddr, pwdata, prdata, rdat, got_addr, a;
  logic [3:0] o, oe, dev, io;
  logic [7:0] got_op;
  logic [2:0] rt;
  logic [1:0] md;
  logic [15:0] lf;
  int n_errors = 0;
  int num_checks = 0;
  int n_cs = 0;
  int i, k;
  assign io = (oe & o) | (~oe & dev);
  sfrc_host i_sfrc_host (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk),
    .io_line_0_in(io[0]), .io_line_0_out(o[0]), .io_line_0_oe(oe[0]),
    .io_line_1_in(io[1]), .io_line_1_out(o[1]), .io_line_1_oe(oe[1]),
    .io_line_2_in(io[2]), .io_line_2_out(o[2]), .io_line_2_oe(oe[2]),
    .io_line_3_in(io[3]), .io_line_3_out(o[3]), .io_line_3_oe(oe[3]));
  sfrc_flash_model i_sfrc_flash_model (.cs_n(flash_cs_n), .sclk(flash_sclk), .io(io),
    .dev(dev), .rtype(rt), .four_wire_command_mode(mq), .wide(mw), .dc(md), .got_op(got_op), .got_addr(got_addr));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(negedge flash_cs_n) n_cs++;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] mem(input logic [31:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [7:0] opc(input logic [2:0] t);
    return t == 3'h1 ? sfrc_pkg::OP_DUAL_OUT : t == 3'h2 ? sfrc_pkg::OP_DUAL_IO :
      t == 3'h3 ? sfrc_pkg::OP_QUAD_OUT : t == 3'h4 ? sfrc_pkg::OP_QUAD_IO : sfrc_pkg::OP_FAST;
  endfunction
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // A free cycle before each setup keeps one assignment per time step
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int c;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, ad};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (pready !== 1'b1 && c < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (c >= 20) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic wait_stat(input int b, input logic v);
    int c;
    c = 0;
    do begin
      apb(1'b0, sfrc_pkg::OFF_STATUS, 32'h0);
      c++;
    end while (rdat[b] !== v && c < 400);
    if (c >= 400) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic do_read(input logic [2:0] t, input logic q, input logic w, input logic [1:0] d,
      input logic [31:0] ad, input int len);
    logic [31:0] ea;
    int j;
    ea = w ? ad : {8'h0, ad[23:0]};
    rt = t;
    mq = q;
    mw = w;
    md = d;
    apb(1'b1, sfrc_pkg::OFF_CTRL, {24'h1, d, 1'b0, w, q, t});
    apb(1'b1, sfrc_pkg::OFF_ADDR, ad);
    apb(1'b1, sfrc_pkg::OFF_LEN, len);
    apb(1'b1, sfrc_pkg::OFF_CMD, 32'h1);
    for (j = 0; j < len; j++) begin
      wait_stat(sfrc_pkg::STAT_VALID_BIT, 1'b1);
      apb(1'b0, sfrc_pkg::OFF_DATA, 32'h0);
      `CHK("data", mem((ea + j) & AMASK), rdat[7:0])
    end
    wait_stat(sfrc_pkg::STAT_ACTIVE_BIT, 1'b0);
    `CHK("opcode", opc(t), got_op)
    `CHK("address", ea, got_addr)
    apb(1'b0, sfrc_pkg::OFF_CUR_ADDR, 32'h0);
    `CHK("next address", (ea + len) & AMASK, rdat)
  endtask
  initial begin
    {psel, penable, pwrite, mq, mw} = 5'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    rt = 3'h0;
    md = 2'h0;
    lf = 16'd27;
    rst = 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, sfrc_pkg::OFF_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rdat)
    apb(1'b0, sfrc_pkg::OFF_LEN, 32'h0);
    `CHK("len reset", 32'h1, rdat)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {rerr, rdat})
    for (i = 0; i < 7; i++) begin
      lf = lfsr(lf);
      a = {lf, lfsr(lf)} & ((i % 2 == 1) ? AMASK : 32'h00ff_ffff);
      if (i == 6) a = 32'h01ff_fffe;
      do_read(i == 6 ? 3'h2 : i > 4 ? 3'h4 : i[2:0], i == 5, i[0] | (i == 6), i[1:0], a,
        3);
    end
    for (i = 0; i < 3; i++) begin
      k = n_cs;
      apb(1'b1, sfrc_pkg::OFF_CTRL, i == 0 ? 32'h200 : i == 1 ? 32'h4 : 32'h0);
      apb(1'b1, sfrc_pkg::OFF_ADDR, i == 2 ? 32'h0100_0000 : 32'h0);
      apb(1'b1, sfrc_pkg::OFF_CMD, 32'h1);
      apb(1'b0, sfrc_pkg::OFF_STATUS, 32'h0);
      `CHK("refused", 4'h4, rdat[3:0])
      `CHK("no select", k, n_cs)
      apb(1'b1, sfrc_pkg::OFF_STATUS, 32'h4);
    end
    {rt, mq, mw, md} = 7'h0;
    apb(1'b1, sfrc_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, sfrc_pkg::OFF_ADDR, 32'h10);
    apb(1'b1, sfrc_pkg::OFF_LEN, 32'h10);
    apb(1'b1, sfrc_pkg::OFF_CMD, 32'h1);
    wait_stat(sfrc_pkg::STAT_VALID_BIT, 1'b1);
    apb(1'b1, sfrc_pkg::OFF_CMD, 32'h2);
    apb(1'b0, sfrc_pkg::OFF_DATA, 32'h0);
    `CHK("first byte", mem(32'h10), rdat[7:0])
    wait_stat(sfrc_pkg::STAT_ACTIVE_BIT, 1'b0);
    `CHK("bytes left", 1'b1, rdat[31:16] != 16'h0)
    `CHK("select off", 1'b1, flash_cs_n)
    final_report();
  end
endmodule
`default_nettype wire
